// ==== pkg/ocs_pkg.sv ====
// Notes on behaviour
// - Outputs one to seven each pick a frequency from main or aux path.
// - Frame pulse 8kHz, multiframe 2kHz, programmable width and polarity.
// - Format bits per differential output choose type or disable it.
// - Each synthesizer adds an increment to a phase accumulator on every cycle with ce high.
// - Accumulator value codes phase; edges placed from that coding.
// - Aux path shares one forward synth; main has output and feedback synths.
// - Main phase offset applies only to the feedback clock.
// - Each feedback synth always follows its own forward synth.
// - Five synths selectable, four fixed to main; lock bit forces main.
// - Frame synth feeds both pulses; tied to main unless independent.
// - Low-rate synth source from its select bit and the lock bit.
// - Synth A frequency from standard bit and 2-bit code.
// - Synth B frequency from alternate bit, standard bit and code.
// - Each digital synth follows its source bit unless lock bit set.
// - Main APLL and second main APLL references always follow main.
// - Aux APLL reference follows aux-to-main bit and lock bit.
// - Second main APLL fixed at 312.5MHz, no frequency select.
// - Aux APLL code 0000 with aux-to-main 0 powers down; outputs low.
// - Each APLL gives one set of divided outputs from one frequency.
// - Main APLL code selects one of seven fixed frequencies; codes 0 and 1 give the same one.
package ocs_pkg;
  // ------------------------------------------------------------
  // Synthesizer instances
  // ------------------------------------------------------------
  localparam int NDFS      = 10;
  localparam int DFS_LOW   = 0;
  localparam int DFS_FRM   = 1;
  localparam int DFS_SA    = 2;
  localparam int DFS_SB    = 3;
  localparam int DFS_MAP   = 4;
  localparam int DFS_AP2   = 5;
  localparam int DFS_XAP   = 6;
  localparam int DFS_MFWD  = 7;
  localparam int DFS_MFB   = 8;
  localparam int DFS_XFWD  = 9;
  localparam logic [63:0] MASTER_KHZ = 64'h0000_0000_0003_2000;
  localparam logic [16:0] LOW_KHZ    = 17'h0_0008;
  localparam logic [16:0] AP2_KHZ    = 17'h0_F424;
  // ------------------------------------------------------------
  // Register offsets (byte addresses) and reset
  // ------------------------------------------------------------
  localparam int NREG = 13;
  localparam logic [5:0] OFF_MC4  = 6'h00;
  localparam logic [5:0] OFF_MC6  = 6'h04;
  localparam logic [5:0] OFF_MC7  = 6'h08;
  localparam logic [5:0] OFF_MC8  = 6'h0C;
  localparam logic [5:0] OFF_MP1  = 6'h10;
  localparam logic [5:0] OFF_XP1  = 6'h14;
  localparam logic [5:0] OFF_FS1  = 6'h18;
  localparam logic [5:0] OFF_FS2  = 6'h1C;
  localparam logic [5:0] OFF_OC1  = 6'h20;
  localparam logic [5:0] OFF_OC5  = 6'h30;
  localparam logic [5:0] OFF_STAT = 6'h34;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] REG_MASK [0:NREG-1] = '{
    16'h0001, 16'h0007, 16'h003F, 16'h00FF, 16'h007F, 16'h000F,
    16'h0FF7, 16'h0001, 16'h00FF, 16'h00FF, 16'h00FF, 16'h000F,
    16'h007F};
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MC4_LOCK  = 0;
  localparam int MC6_SA_SS = 0;
  localparam int MC6_SB_SS = 1;
  localparam int MC6_SB_AF = 2;
  localparam int MC7_SA_F  = 0;
  localparam int MC7_SB_F  = 2;
  localparam int MC7_SA_SRC = 4;
  localparam int MC7_SB_SRC = 5;
  localparam int MP1_FREQ  = 0;
  localparam int MP1_XTOM  = 3;
  localparam int MP1_FT4   = 4;
  localparam int FS1_SRC   = 0;
  localparam int FS1_FPOL  = 1;
  localparam int FS1_MPOL  = 2;
  localparam int FS1_FW    = 4;
  localparam int FS1_MW    = 8;
  localparam int FS2_FRAME_SYNC_INDEPENDENT = 0;
  // ------------------------------------------------------------
  // Output selections and formats
  // ------------------------------------------------------------
  localparam logic [3:0] OSEL_8K  = 4'h1;
  localparam logic [3:0] OSEL_2K  = 4'h2;
  localparam logic [3:0] OSEL_SA  = 4'h3;
  localparam logic [3:0] OSEL_SB  = 4'h4;
  localparam logic [3:0] OSEL_AD1 = 4'h5;
  localparam logic [3:0] OSEL_AD8 = 4'h8;
  localparam logic [3:0] OSEL_AP2 = 4'h9;
  localparam logic [1:0] FMT_LVDS = 2'h1;
  localparam logic [1:0] FMT_PECL = 2'h2;
endpackage

// ==== pkg/ocs_dfs_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ocs_dfs_if;
  logic        ce;
  logic [31:0] inc;
  logic [31:0] phase;
  modport synth (input ce, input inc, output phase);
  modport ctrl  (output ce, output inc, input phase);
endinterface
`default_nettype wire

// ==== logic/ocs_dfs.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocs_dfs (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Control side
  ocs_dfs_if.synth  bus
);
  logic [31:0] acc_r;
  // ----------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------
  // Add increment
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= 32'h0000_0000;
    end else if (bus.ce) begin
      acc_r <= acc_r + bus.inc;
    end
  end
  assign bus.phase = acc_r;
endmodule // ocs_dfs
`default_nettype wire

// ==== logic/ocs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocs_top (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // DPLL frequency trims and main phase offset
  input  wire logic [15:0] main_dpll_trim,
  input  wire logic [15:0] aux_dpll_trim,
  input  wire logic [15:0] main_phase_offset,
  // Output clocks one to five, single ended
  output logic      [4:0]  out_cmos,
  // Output clocks four to seven, differential
  output logic      [3:0]  diff_clk_p,
  output logic      [3:0]  diff_clk_n,
  output logic      [3:0]  diff_lvpecl,
  output logic      [3:0]  diff_oe,
  // Frame pulses
  output logic             frame_pulse_out,
  output logic             multiframe_pulse_out,
  // Feedback clocks and APLL state
  output logic             main_fb_clk,
  output logic             aux_fb_clk,
  output logic             aux_apll_pd
);

  // ------------------------------------------------------------
  // Decode functions
  // ------------------------------------------------------------
  // Phase increment for a frequency in kHz
  function automatic logic [31:0] khz_inc(input logic [16:0] khz);
    logic [63:0] t;
    t = ({47'h0, khz} << 32) / ocs_pkg::MASTER_KHZ;
    return t[31:0];
  endfunction

  // Byte-lane merge for the low two lanes
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Synth A rates, shared by synth B when alternate is clear
  function automatic logic [16:0] sa_khz(input logic ss,
                                         input logic [1:0] f);
    logic [16:0] base;
    base = ss ? 17'h0_0608 : 17'h0_0800;
    return base << f;
  endfunction

  // Main APLL reference rate, quarter of APLL rate
  function automatic logic [16:0] map_khz(input logic [2:0] c);
    logic [16:0] k;
    k = 17'h0_0000;
    unique case (c)
      3'h0, 3'h1: k = 17'h1_2FC0;
      3'h2:       k = 17'h0_6000;
      3'h3:       k = 17'h0_8000;
      3'h4:       k = 17'h0_90C0;
      3'h5:       k = 17'h0_6080;
      3'h6:       k = 17'h0_62A0;
      3'h7:       k = 17'h0_F424;
    endcase
    return k;
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [15:0] cfg_r [0:ocs_pkg::NREG-1];
  logic [3:0]  idx;
  logic        acc_go;
  assign idx    = avs_address[5:2];
  assign acc_go = avs_waitrequest == 1'b0;

  logic        lock;
  logic [15:0] mc6;
  logic [15:0] mc7;
  logic [15:0] mc8;
  logic [15:0] mp1;
  logic [15:0] xp1;
  logic [15:0] fs1;
  logic [15:0] oc5;
  assign lock = cfg_r[ocs_pkg::OFF_MC4[5:2]][ocs_pkg::MC4_LOCK];
  assign mc6  = cfg_r[ocs_pkg::OFF_MC6[5:2]];
  assign mc7  = cfg_r[ocs_pkg::OFF_MC7[5:2]];
  assign mc8  = cfg_r[ocs_pkg::OFF_MC8[5:2]];
  assign mp1  = cfg_r[ocs_pkg::OFF_MP1[5:2]];
  assign xp1  = cfg_r[ocs_pkg::OFF_XP1[5:2]];
  assign fs1  = cfg_r[ocs_pkg::OFF_FS1[5:2]];
  assign oc5  = cfg_r[ocs_pkg::OFF_OC5[5:2]];

  // ------------------------------------------------------------
  // Source routing, 1 means aux path
  // ------------------------------------------------------------
  logic src_low;
  logic src_frm;
  logic src_sa;
  logic src_sb;
  logic src_xap;
  logic xtom;
  assign src_low = fs1[ocs_pkg::FS1_SRC] & ~lock;
  // Frame synth on main unless independent
  assign src_frm = cfg_r[ocs_pkg::OFF_FS2[5:2]][ocs_pkg::FS2_FRAME_SYNC_INDEPENDENT] & ~lock;
  assign src_sa  = mc7[ocs_pkg::MC7_SA_SRC] & ~lock;
  assign src_sb  = mc7[ocs_pkg::MC7_SB_SRC] & ~lock;
  assign xtom    = mp1[ocs_pkg::MP1_XTOM];
  assign src_xap = ~xtom & ~lock;

  logic xap_off;
  assign xap_off = (xp1[3:0] == 4'h0) && !xtom;

  // ------------------------------------------------------------
  // Synthesizer increments
  // ------------------------------------------------------------
  logic [31:0] trim_m;
  logic [31:0] trim_x;
  assign trim_m = {{16{main_dpll_trim[15]}}, main_dpll_trim};
  assign trim_x = {{16{aux_dpll_trim[15]}}, aux_dpll_trim};

  logic [16:0] sb_khz;
  logic [16:0] xap_khz;
  logic [1:0]  sbf;
  logic        sbss;
  assign sbf  = mc7[ocs_pkg::MC7_SB_F +: 2];
  assign sbss = mc6[ocs_pkg::MC6_SB_SS];

  // Synth B rate; undefined alternate codes stop the synth
  always_comb begin
    sb_khz = 17'h0_0000;
    if (!mc6[ocs_pkg::MC6_SB_AF]) begin
      sb_khz = sa_khz(sbss, sbf);
    end else begin
      unique case ({sbss, sbf})
        3'h0:    sb_khz = 17'h0_18A8;
        3'h2:    sb_khz = 17'h0_2710;
        3'h4:    sb_khz = 17'h0_4BF0;
        3'h5:    sb_khz = 17'h0_97E0;
        default: sb_khz = 17'h0_0000;
      endcase
    end
  end

  // Aux APLL rate; tied mode reuses the main table
  always_comb begin
    xap_khz = 17'h0_0000;
    if (xtom) begin
      xap_khz = map_khz(mp1[ocs_pkg::MP1_FT4 +: 3]);
    end else begin
      unique case (xp1[3:0])
        4'h1:    xap_khz = 17'h1_2FC0;
        4'h2:    xap_khz = 17'h0_6000;
        4'h3:    xap_khz = 17'h0_8000;
        4'h4:    xap_khz = 17'h0_90C0;
        4'h5:    xap_khz = 17'h0_6080;
        4'h6:    xap_khz = 17'h1_0C80;
        default: xap_khz = 17'h0_0000;
      endcase
    end
  end

  logic [31:0] inc_w [0:ocs_pkg::NDFS-1];
  logic [31:0] ph_w  [0:ocs_pkg::NDFS-1];
  logic [31:0] mfwd_inc;
  // Main forward rate, shared by the forward and feedback synths
  assign mfwd_inc = khz_inc(ocs_pkg::LOW_KHZ) + trim_m;
  // Five selectable synths, four fixed to main
  // Low-rate and frame synths run at 2kHz; bit 29 then gives 8kHz,
  // since no accumulator bit can run slower than its own MSB
  assign inc_w[ocs_pkg::DFS_LOW]  = khz_inc(ocs_pkg::LOW_KHZ >> 2)
                                  + (src_low ? trim_x : trim_m);
  assign inc_w[ocs_pkg::DFS_FRM]  = khz_inc(ocs_pkg::LOW_KHZ >> 2)
                                  + (src_frm ? trim_x : trim_m);
  assign inc_w[ocs_pkg::DFS_SA]   = khz_inc(sa_khz(mc6[ocs_pkg::MC6_SA_SS],
                                    mc7[ocs_pkg::MC7_SA_F +: 2]))
                                  + (src_sa ? trim_x : trim_m);
  assign inc_w[ocs_pkg::DFS_SB]   = (sb_khz == 17'h0_0000) ? 32'h0000_0000
                                  : khz_inc(sb_khz)
                                  + (src_sb ? trim_x : trim_m);
  // Main APLL reference on main only
  assign inc_w[ocs_pkg::DFS_MAP]  = khz_inc(map_khz(mp1[2:0])) + trim_m;
  assign inc_w[ocs_pkg::DFS_AP2]  = khz_inc(ocs_pkg::AP2_KHZ) + trim_m;
  assign inc_w[ocs_pkg::DFS_XAP]  = xap_off ? 32'h0000_0000
                                  : khz_inc(xap_khz)
                                  + (src_xap ? trim_x : trim_m);
  assign inc_w[ocs_pkg::DFS_MFWD] = mfwd_inc;
  assign inc_w[ocs_pkg::DFS_MFB]  = mfwd_inc;
  assign inc_w[ocs_pkg::DFS_XFWD] = khz_inc(ocs_pkg::LOW_KHZ) + trim_x;

  // ------------------------------------------------------------
  // Synthesizer bank
  // ------------------------------------------------------------
  ocs_dfs_if dfs_bus [ocs_pkg::NDFS] ();
  genvar g;
  generate
    for (g = 0; g < ocs_pkg::NDFS; g++) begin : g_dfs
      assign dfs_bus[g].ce  = ce;
      assign dfs_bus[g].inc = inc_w[g];
      assign ph_w[g]        = dfs_bus[g].phase;
      ocs_dfs u_dfs (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .bus     (dfs_bus[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Output clock selection
  // ------------------------------------------------------------
  // Each APLL output divides one accumulator, so one rate set
  logic [6:0] sel_clk;
  generate
    for (g = 0; g < 7; g++) begin : g_sel
      logic [3:0]  code;
      logic [31:0] aph;
      logic        aoff;
      assign code = cfg_r[ocs_pkg::OFF_OC1[5:2] + g / 2][(g % 2) * 4 +: 4];
      assign aph  = oc5[g] ? ph_w[ocs_pkg::DFS_XAP]
                           : ph_w[ocs_pkg::DFS_MAP];
      assign aoff = oc5[g] & xap_off;
      always_comb begin
        sel_clk[g] = 1'b0;
        if (code == ocs_pkg::OSEL_8K) begin
          sel_clk[g] = ph_w[ocs_pkg::DFS_LOW][29];
        end else if (code == ocs_pkg::OSEL_2K) begin
          sel_clk[g] = ph_w[ocs_pkg::DFS_LOW][31];
        end else if (code == ocs_pkg::OSEL_SA) begin
          sel_clk[g] = ph_w[ocs_pkg::DFS_SA][31];
        end else if (code == ocs_pkg::OSEL_SB) begin
          sel_clk[g] = ph_w[ocs_pkg::DFS_SB][31];
        end else if (code >= ocs_pkg::OSEL_AD1 &&
                     code <= ocs_pkg::OSEL_AD8) begin
          // Fed from a powered-down APLL: low
          sel_clk[g] = aoff ? 1'b0
                     : aph[31 - 32'(code - ocs_pkg::OSEL_AD1)];
        end else if (code == ocs_pkg::OSEL_AP2) begin
          sel_clk[g] = ph_w[ocs_pkg::DFS_AP2][31];
        end
      end
    end
  endgenerate

  // Edge lands on the next clock; coarse but jitter is bounded
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_cmos <= 5'h00;
    end else if (ce) begin
      out_cmos <= sel_clk[4:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      diff_clk_p  <= 4'h0;
      diff_clk_n  <= 4'h0;
      diff_lvpecl <= 4'h0;
      diff_oe     <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++) begin
        logic [1:0] f;
        logic       en;
        f  = mc8[i*2 +: 2];
        en = (f == ocs_pkg::FMT_LVDS) || (f == ocs_pkg::FMT_PECL);
        diff_oe[i]     <= en;
        diff_lvpecl[i] <= f == ocs_pkg::FMT_PECL;
        diff_clk_p[i]  <= en & sel_clk[i+3];
        diff_clk_n[i]  <= en & ~sel_clk[i+3];
      end
    end
  end

  // ------------------------------------------------------------
  // Feedback clocks
  // ------------------------------------------------------------
  logic [31:0] fb_ph;
  assign fb_ph = ph_w[ocs_pkg::DFS_MFB] + {main_phase_offset, 16'h0000};
  // Aux feedback taken from its single forward synth
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_fb_clk <= 1'b0;
      aux_fb_clk  <= 1'b0;
      aux_apll_pd <= 1'b0;
    end else if (ce) begin
      main_fb_clk <= fb_ph[31];
      aux_fb_clk  <= ph_w[ocs_pkg::DFS_XFWD][31];
      aux_apll_pd <= xap_off;
    end
  end

  // ------------------------------------------------------------
  // Frame and multiframe pulses
  // ------------------------------------------------------------
  logic       frm_msb_r;
  logic [4:0] fcnt_r;
  logic [4:0] mcnt_r;
  logic       fact;
  logic       mact;
  logic       frm_edge;
  // Frame edge on the 8kHz bit 29; a 5-bit count keeps width 16 alive
  assign frm_edge = ph_w[ocs_pkg::DFS_FRM][29] & ~frm_msb_r;
  assign fact = fcnt_r != 5'h00;
  assign mact = mcnt_r != 5'h00;

  // Both pulses from the frame synth; every fourth is multiframe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frm_msb_r <= 1'b0;
      fcnt_r    <= 5'h00;
      mcnt_r    <= 5'h00;
    end else if (ce) begin
      frm_msb_r <= ph_w[ocs_pkg::DFS_FRM][29];
      if (frm_edge) begin
        fcnt_r <= {1'b0, fs1[ocs_pkg::FS1_FW +: 4]} + 5'h01;
      end else if (fact) begin
        fcnt_r <= fcnt_r - 5'h01;
      end
      if (frm_edge && ph_w[ocs_pkg::DFS_FRM][31:30] == 2'h0) begin
        mcnt_r <= {1'b0, fs1[ocs_pkg::FS1_MW +: 4]} + 5'h01;
      end else if (mact) begin
        mcnt_r <= mcnt_r - 5'h01;
      end
    end
  end

  // Width from counters, polarity by xor
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_pulse_out      <= 1'b0;
      multiframe_pulse_out <= 1'b0;
    end else if (ce) begin
      frame_pulse_out      <= fact ^ fs1[ocs_pkg::FS1_FPOL];
      multiframe_pulse_out <= mact ^ fs1[ocs_pkg::FS1_MPOL];
    end
  end

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  logic [15:0] stat;
  assign stat = {10'h000, src_frm, src_xap, src_low, src_sb, src_sa,
                 xap_off};

  // One wait cycle per access; answer on the second cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        if (idx < 4'(ocs_pkg::NREG)) begin
          avs_readdata <= {16'h0000, cfg_r[idx]};
        end else if (idx == ocs_pkg::OFF_STAT[5:2]) begin
          avs_readdata <= {16'h0000, stat};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Register writes; lanes two and three hold nothing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ocs_pkg::NREG; i++) begin
        cfg_r[i] <= ocs_pkg::CFG_RST;
      end
    end else if (ce) begin
      if (avs_write && acc_go && idx < 4'(ocs_pkg::NREG)) begin
        cfg_r[idx] <= be_merge(cfg_r[idx], avs_writedata[15:0],
                               avs_byteenable[1:0])
                    & ocs_pkg::REG_MASK[idx];
      end
    end
  end

endmodule // ocs_top
`default_nettype wire

// ==== test/ocs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocs_sva (
  // Clock, reset, enable
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       ce,
  // Bus handshake
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // Clock outputs
  input wire logic [4:0] out_cmos,
  input wire logic [3:0] diff_clk_p,
  input wire logic [3:0] diff_clk_n,
  input wire logic [3:0] diff_oe,
  input wire logic       frame_pulse_out,
  input wire logic       multiframe_pulse_out
);
  logic        fs_q_r;
  logic        seen_r;
  logic [15:0] gap_r;
  wire         fs_rise = frame_pulse_out & ~fs_q_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Frame gap count; a write or a freeze voids it, as either may shift phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fs_q_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r  <= 16'h0000;
    end else begin
      fs_q_r <= frame_pulse_out;
      gap_r  <= fs_rise ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= (seen_r | fs_rise) & ce & ~avs_write;
    end
  end
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest)
    else $error("bus request not answered in the next cycle");
  answer_once_a: assert property (
    !avs_waitrequest && ce |=> avs_waitrequest)
    else $error("bus answer held longer than one cycle");
  idle_wait_a: assert property (
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer without a request");
  diff_off_a: assert property (
    ((diff_clk_p | diff_clk_n) & ~diff_oe) == 4'h0)
    else $error("disabled differential output toggles");
  freeze_a: assert property (
    !ce |=> $stable(out_cmos) && $stable(frame_pulse_out))
    else $error("outputs moved while the enable was low");
  rst_vals_a: assert property (
    $rose(rst_b) |-> avs_waitrequest && out_cmos == 5'h00 && diff_oe == 4'h0)
    else $error("outputs not at reset values after release");
  frame_gap_a: assert property (
    fs_rise && seen_r |-> gap_r >= 16'd25599 && gap_r <= 16'd25601)
    else $error("frame pulse period wrong");
  mf_on_frame_a: assert property (
    $rose(multiframe_pulse_out) |-> $rose(frame_pulse_out))
    else $error("multiframe pulse not aligned to a frame pulse");
endmodule // ocs_sva
bind ocs_top ocs_sva i_sva (.ref_clk, .rst_b, .ce, .avs_read, .avs_write,
  .avs_waitrequest, .out_cmos, .diff_clk_p, .diff_clk_n, .diff_oe,
  .frame_pulse_out, .multiframe_pulse_out);
`default_nettype wire

// ==== test/ocs_rx_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocs_rx_model (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Receiver lines
  input wire logic        clr,
  input wire logic [4:0]  out_cmos,
  output logic     [15:0] edges
);
  logic prev_r;
  // Line card receiver counting rising edges of output one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b0;
      edges  <= 16'h0000;
    end else begin
      prev_r <= out_cmos[0];
      if (clr)
        edges <= 16'h0000;
      else if (out_cmos[0] && !prev_r)
        edges <= edges + 16'h0001;
    end
  end
endmodule // ocs_rx_model
`default_nettype wire

// ==== test/ocs_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocs_top_bench;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        clr = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, fs, mfs, pd;
  logic [4:0]  out_cmos;
  logic [3:0]  doe, pecl;
  logic [15:0] edges;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          tick = 0;
  // Synth settings and rates in kHz: A codes, then B codes
  int          m6 [13] = '{0,0,0,0,1,1,1,1,4,4,6,6,2};
  int          m7 [13] = '{0,1,2,3,0,1,2,3,0,8,0,4,12};
  int          sk [13] = '{2048,4096,8192,16384,1544,3088,6176,12352,
                           6312,10000,19440,38880,12352};
  int          ak [8] = '{77760,77760,24576,32768,37056,24704,25248,62500};
  always #10 ref_clk = ~ref_clk;
  ocs_top i_dut (.ref_clk, .rst_b, .ce, .avs_address, .avs_read, .avs_write,
    .avs_byteenable(4'h3), .avs_writedata, .avs_readdata, .avs_waitrequest,
    .main_dpll_trim(16'h0000), .aux_dpll_trim(16'h0000),
    .main_phase_offset(16'h0000), .out_cmos, .diff_clk_p(), .diff_clk_n(),
    .diff_lvpecl(pecl), .diff_oe(doe), .frame_pulse_out(fs),
    .multiframe_pulse_out(mfs), .main_fb_clk(), .aux_fb_clk(),
    .aux_apll_pd(pd));
  ocs_rx_model i_rx (.ref_clk, .rst_b, .clr, .out_cmos, .edges);
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the longest expected run
  always @(posedge ref_clk) begin
    tick++;
    if (tick == 95000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Avalon master; request held until waitrequest is seen low
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Answer comes one cycle after the request is taken
    cmp(n, 2);
    @(posedge ref_clk);
  endtask
  // Edges of output one over 1000 cycles against the rate
  task automatic meas(input int khz);
    int e;
    e = 1000 * khz / 204800;
    repeat (20) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (1000) @(posedge ref_clk);
    cmp_rng(edges, e - (e > 0), e + 1);
  endtask
  task automatic t_regs;
    bus(0, 6'h38, 0);
    cmp(rd, 0);
    bus(0, ocs_pkg::OFF_MC8, 0);
    cmp(doe, 0);
    bus(1, ocs_pkg::OFF_MC8, 32'h0000_00E4);
    bus(0, ocs_pkg::OFF_MC8, 0);
    cmp(rd, 32'h0000_00E4);
    cmp(doe, 4'h6);
    cmp(pecl, 4'h4);
  endtask
  task automatic t_src;
    logic [5:0] b;
    logic [5:0] x;
    for (int i = 63; i >= 0; i--) begin
      b = 6'(i);
      bus(1, ocs_pkg::OFF_MP1, {28'h0, b[1], 3'h0});
      bus(1, ocs_pkg::OFF_XP1, 0);
      bus(1, ocs_pkg::OFF_MC7, {26'h0, b[3], b[2], 4'h0});
      bus(1, ocs_pkg::OFF_FS1, b[4]);
      bus(1, ocs_pkg::OFF_FS2, b[5]);
      bus(1, ocs_pkg::OFF_MC4, b[0]);
      bus(0, ocs_pkg::OFF_STAT, 0);
      x = {b[5], ~b[1], b[4:2], !b[1]} & {{5{~b[0]}}, 1'b1};
      cmp(rd, x);
      cmp(pd, !b[1]);
    end
  endtask
  task automatic t_synth;
    for (int k = 0; k < 13; k++) begin
      bus(1, ocs_pkg::OFF_MC6, m6[k]);
      bus(1, ocs_pkg::OFF_MC7, m7[k]);
      bus(1, ocs_pkg::OFF_OC1, k < 8 ? ocs_pkg::OSEL_SA : ocs_pkg::OSEL_SB);
      meas(sk[k]);
    end
  endtask
  task automatic t_apll;
    bus(1, ocs_pkg::OFF_OC1, ocs_pkg::OSEL_AD1);
    for (int k = 0; k < 8; k++) begin
      bus(1, ocs_pkg::OFF_MP1, k);
      meas(ak[k]);
    end
    bus(1, ocs_pkg::OFF_MP1, 0);
    bus(1, ocs_pkg::OFF_XP1, 0);
    bus(1, ocs_pkg::OFF_OC5, 1);
    meas(0);
    cmp(pd, 1);
    bus(1, ocs_pkg::OFF_XP1, 1);
    meas(77760);
    cmp(pd, 0);
    bus(1, ocs_pkg::OFF_OC1, ocs_pkg::OSEL_AP2);
    meas(62500);
    ce <= 1'b0;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (50) @(posedge ref_clk);
    cmp(edges, 0);
    ce <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic t_frame;
    int c;
    int r;
    logic p;
    c = 0;
    r = 0;
    p = fs;
    while (r < 2 && c < 60000) begin
      @(posedge ref_clk);
      c++;
      if (fs === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1)
          c = 0;
      end
      p = fs;
    end
    cmp_rng(c, 25599, 25601);
    bus(1, ocs_pkg::OFF_FS1, 32'h0000_0006);
    repeat (3) @(posedge ref_clk);
    cmp({fs, mfs}, 2'h3);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_src();
    t_synth();
    t_apll();
    t_frame();
    test_done();
  end
endmodule // ocs_top_bench
`default_nettype wire
